/* File: src/scl_cfg.svh */
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH

// Register addresses on the plain register port.
`define SCL_CTL_ADDR      8'hf8
`define SCL_CFG_ADDR      8'ha1
`define SCL_DAT_ADDR      8'ha3

// Control register field positions.
`define SCL_B_DONE        7
`define SCL_B_WRITE_COLLISION_FLAG        6
`define SCL_B_MODE_FAULT_FLAG        5
`define SCL_B_OVRN        4
`define SCL_B_MODE_HI     3
`define SCL_B_MODE_LO     2
`define SCL_B_TXE         1
`define SCL_B_EN          0

// Configuration register field positions.
`define SCL_B_MASTER      6
`define SCL_B_RXAVAIL     1
`define SCL_B_BUSY        0

// Reset values and select pin mode codes.
`define SCL_CTL_RST       8'h06
`define SCL_MODE_3WIRE    2'h0
`define SCL_MODE_4WIRE    2'h1

// System clock cycles per serial clock half period in master mode.
`define SCL_HALF_DEFAULT  8'h04

// Bits per transfer.
`define SCL_BITS          4'h8

`endif

/* File: src/scl_pkg.sv */
`default_nettype none

package scl_pkg;

    // Transfer engine state.
    typedef enum logic {
        SCL_IDLE = 1'b0,
        SCL_XFER = 1'b1
    } scl_st_e;

    // State of the control and status block, apart from its receive buffer.
    typedef struct packed {
        logic       done_f;
        logic       write_collision_flag_f;
        logic       mode_fault_flag_f;
        logic       ovrn_f;
        logic [1:0] mode;
        logic       txe;
        logic       en;
        logic       mst;
        logic [7:0] tx_buf;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [7:0] div;
        scl_st_e    st;
        logic       sck_o;
        logic       so;
        logic [7:0] rdata;
        logic       push;
        logic [7:0] push_data;
        logic       sck_s1;
        logic       sck_s2;
        logic       sck_s3;
        logic       mosi_s1;
        logic       mosi_s2;
        logic       miso_s1;
        logic       miso_s2;
        logic       nss_s1;
        logic       nss_s2;
    } scl_state_s;

endpackage

`default_nettype wire

/* File: src/scl_buf.sv */
`timescale 1ns/1ps
`default_nettype none

// Small ring buffer with valid and ready on both sides.
module scl_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Filling side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } scl_buf_s;

    scl_buf_s s_r;
    scl_buf_s s_nxt;
    logic     do_wr;
    logic     do_rd;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (s_r.cnt != CW'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    // Pointers wrap explicitly so any depth works, not only powers of two.
    always_comb begin
        s_nxt = s_r;
        if (do_wr) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
        end
        if (do_rd) begin
            s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + CW'(do_wr) - CW'(do_rd);
    end

    // State register.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: src/scl_ctl.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "scl_cfg.svh"

//Contract
//- Transfer-done flag, bit 7, sets when a byte transfer finishes.
//- With interrupts enabled, any set flag raises the interrupt.
//- Write-collision flag, bit 6, sets on a data write while buffer full.
//- A colliding data write is dropped; transmit buffer keeps its contents.
//- Mode-fault flag, bit 5, sets on select low, master on, mode 01.
//- Overrun flag, bit 4, sets when last bit arrives with unread data.
//- Overrun is only flagged while operating as a slave.
//- Mode 00 is three-wire; select pin unused and undriven.
//- Mode 01, the default, is four-wire; select pin is an input.
//- Mode 1x drives the select pin with the mode field's low bit.
//- Transmit-empty bit 1 clears when the transmit buffer is written.
//- Transmit-empty sets when the buffer moves into the shift register.
//- Enable bit 0 turns the whole port off or on.
//- Master-enable bit chooses slave when 0, master when 1.
//- In master mode a data write loads the buffer and starts a transfer.
module scl_ctl
    import scl_pkg::*;
#(
    parameter logic [7:0] HALF_CYC = `SCL_HALF_DEFAULT
) (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Register port.
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Interrupt.
    input  wire logic       irq_enable,
    output logic            irq,
    // Serial clock pin.
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    // Master-out data pin.
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe,
    // Master-in data pin.
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe,
    // Slave select pin.
    input  wire logic       nss_in,
    output logic            nss_out,
    output logic            nss_oe
);
    import scl_pkg::*;

    scl_state_s s_r;
    scl_state_s s_nxt;
    logic       rx_in_ready;
    logic       rx_out_valid;
    logic [7:0] rx_out_data;
    logic       rd_pop;
    logic       slave_sel;
    logic       slave_act;
    logic       sck_rise;
    logic       sck_fall;
    logic       m_tick;
    logic       m_start;
    logic       m_done;
    logic       s_done;
    logic       dat_wr;
    logic       ctl_wr;

    // Event terms shared by the engine and the checks below.
    assign sck_rise  = s_r.sck_s2 & ~s_r.sck_s3;
    assign sck_fall  = ~s_r.sck_s2 & s_r.sck_s3;
    assign slave_sel = (s_r.mode == `SCL_MODE_3WIRE) | ~s_r.nss_s2;
    assign slave_act = s_r.en & ~s_r.mst & slave_sel;
    assign m_tick    = (s_r.div == HALF_CYC - 8'h01);
    assign m_start   = s_r.en & s_r.mst & (s_r.st == SCL_IDLE) & ~s_r.txe
                       & rx_in_ready & ~s_r.push;
    assign m_done    = s_r.en & s_r.mst & (s_r.st == SCL_XFER) & m_tick & s_r.sck_o
                       & (s_r.cnt == `SCL_BITS);
    assign s_done    = slave_act & sck_rise & (s_r.cnt == `SCL_BITS - 4'h1);
    assign dat_wr    = reg_wr & (reg_addr == `SCL_DAT_ADDR);
    assign ctl_wr    = reg_wr & (reg_addr == `SCL_CTL_ADDR);
    assign rd_pop    = reg_rd & (reg_addr == `SCL_DAT_ADDR) & rx_out_valid;

    // Received bytes wait here; a slow reader stalls the master engine.
    scl_buf #(
        .W     (8),
        .DEPTH (2)
    ) u_rx_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (s_r.push),
        .in_ready  (rx_in_ready),
        .in_data   (s_r.push_data),
        .out_valid (rx_out_valid),
        .out_ready (rd_pop),
        .out_data  (rx_out_data)
    );

    // Next-state logic; hardware sets come after software writes so a set wins.
    always_comb begin
        s_nxt = s_r;
        s_nxt.sck_s1  = sck_in;
        s_nxt.sck_s2  = s_r.sck_s1;
        s_nxt.sck_s3  = s_r.sck_s2;
        s_nxt.mosi_s1 = mosi_in;
        s_nxt.mosi_s2 = s_r.mosi_s1;
        s_nxt.miso_s1 = miso_in;
        s_nxt.miso_s2 = s_r.miso_s1;
        s_nxt.nss_s1  = nss_in;
        s_nxt.nss_s2  = s_r.nss_s1;
        if (rx_in_ready) begin
            s_nxt.push = 1'b0;
        end
        // Read data stands for exactly one cycle after the strobe.
        s_nxt.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `SCL_CTL_ADDR: s_nxt.rdata = {s_r.done_f, s_r.write_collision_flag_f, s_r.mode_fault_flag_f, s_r.ovrn_f,
                                              s_r.mode, s_r.txe, s_r.en};
                `SCL_CFG_ADDR: s_nxt.rdata = {1'b0, s_r.mst, 4'h0, rx_out_valid,
                                              (s_r.st == SCL_XFER)};
                `SCL_DAT_ADDR: s_nxt.rdata = rx_out_valid ? rx_out_data : 8'h00;
                default:       s_nxt.rdata = 8'h00;
            endcase
        end
        if (ctl_wr) begin
            s_nxt.done_f = reg_wdata[`SCL_B_DONE];
            s_nxt.write_collision_flag_f = reg_wdata[`SCL_B_WRITE_COLLISION_FLAG];
            s_nxt.mode_fault_flag_f = reg_wdata[`SCL_B_MODE_FAULT_FLAG];
            s_nxt.ovrn_f = reg_wdata[`SCL_B_OVRN];
            s_nxt.mode   = reg_wdata[`SCL_B_MODE_HI:`SCL_B_MODE_LO];
            s_nxt.en     = reg_wdata[`SCL_B_EN];
        end
        if (reg_wr && reg_addr == `SCL_CFG_ADDR) begin
            s_nxt.mst = reg_wdata[`SCL_B_MASTER];
        end
        if (dat_wr) begin
            if (!s_r.txe) begin
                s_nxt.write_collision_flag_f = 1'b1;
            end else begin
                s_nxt.tx_buf = reg_wdata;
                s_nxt.txe    = 1'b0;
            end
        end
        if (s_r.en && s_r.mst && s_r.mode == `SCL_MODE_4WIRE && !s_r.nss_s2) begin
            s_nxt.mode_fault_flag_f = 1'b1;
        end
        if (!s_r.en) begin
            // A disabled port holds its engine idle and its clock low.
            s_nxt.st    = SCL_IDLE;
            s_nxt.cnt   = 4'h0;
            s_nxt.div   = 8'h00;
            s_nxt.sck_o = 1'b0;
        end else if (s_r.mst) begin
            unique case (s_r.st)
                SCL_IDLE: begin
                    s_nxt.sck_o = 1'b0;
                    if (m_start) begin
                        s_nxt.sh  = s_r.tx_buf;
                        s_nxt.so  = s_r.tx_buf[7];
                        s_nxt.txe = 1'b1;
                        s_nxt.cnt = 4'h0;
                        s_nxt.div = 8'h00;
                        s_nxt.st  = SCL_XFER;
                    end
                end
                SCL_XFER: begin
                    s_nxt.div = m_tick ? 8'h00 : s_r.div + 8'h01;
                    if (m_tick && !s_r.sck_o) begin
                        // Rising edge samples the peer.
                        s_nxt.sck_o = 1'b1;
                        s_nxt.sh    = {s_r.sh[6:0], s_r.miso_s2};
                        s_nxt.cnt   = s_r.cnt + 4'h1;
                    end else if (m_tick) begin
                        s_nxt.sck_o = 1'b0;
                        s_nxt.so    = s_r.sh[7];
                        if (m_done) begin
                            s_nxt.done_f    = 1'b1;
                            s_nxt.push      = 1'b1;
                            s_nxt.push_data = s_r.sh;
                            s_nxt.st        = SCL_IDLE;
                        end
                    end
                end
            endcase
        end else if (!slave_sel) begin
            // Deselection abandons any partial byte.
            s_nxt.cnt = 4'h0;
            s_nxt.st  = SCL_IDLE;
        end else begin
            if (s_r.cnt == 4'h0 && s_r.st == SCL_IDLE && !s_r.txe) begin
                s_nxt.sh  = s_r.tx_buf;
                s_nxt.so  = s_r.tx_buf[7];
                s_nxt.txe = 1'b1;
                s_nxt.st  = SCL_XFER;
            end
            if (sck_rise) begin
                s_nxt.sh  = {s_r.sh[6:0], s_r.mosi_s2};
                s_nxt.cnt = s_r.cnt + 4'h1;
            end else if (sck_fall) begin
                s_nxt.so = s_r.sh[7];
            end
            if (s_done) begin
                // The peer cannot be stalled, so unread data is reported instead.
                s_nxt.done_f    = 1'b1;
                s_nxt.ovrn_f    = s_r.ovrn_f | rx_out_valid;
                s_nxt.push      = 1'b1;
                s_nxt.push_data = {s_r.sh[6:0], s_r.mosi_s2};
                s_nxt.cnt       = 4'h0;
                s_nxt.st        = SCL_IDLE;
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r         <= '0;
            s_r.mode    <= 2'(`SCL_CTL_RST >> `SCL_B_MODE_LO);
            s_r.txe     <= 1'b1;
            s_r.sck_s1  <= 1'b0;
            s_r.nss_s1  <= 1'b1;
            s_r.nss_s2  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pin drivers; the select pin is only driven in single-master mode.
    assign reg_rdata = s_r.rdata;
    assign irq       = irq_enable & (s_r.done_f | s_r.write_collision_flag_f | s_r.mode_fault_flag_f | s_r.ovrn_f);
    assign sck_out   = s_r.sck_o;
    assign sck_oe    = s_r.en & s_r.mst;
    assign mosi_out  = s_r.so;
    assign mosi_oe   = s_r.en & s_r.mst;
    assign miso_out  = s_r.so;
    assign miso_oe   = slave_act;
    assign nss_out   = s_r.mode[0];
    assign nss_oe    = s_r.en & s_r.mode[1];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_DONE_SETS: assert property ((m_done || s_done) |=> s_r.done_f)
        else $error("transfer done flag not set");
    // Flags only fall on a software write to the control register.
    AST_FLAGS_HOLD: assert property ((s_r.done_f && !ctl_wr) |=> s_r.done_f)
        else $error("done flag cleared without a write");
    AST_WRITE_COLLISION_FLAG_HOLD: assert property ((s_r.write_collision_flag_f && !ctl_wr) |=> s_r.write_collision_flag_f)
        else $error("collision flag cleared without a write");
    AST_MODE_FAULT_FLAG_HOLD: assert property ((s_r.mode_fault_flag_f && !ctl_wr) |=> s_r.mode_fault_flag_f)
        else $error("mode fault flag cleared without a write");
    AST_OVRN_HOLD: assert property ((s_r.ovrn_f && !ctl_wr) |=> s_r.ovrn_f)
        else $error("overrun flag cleared without a write");
    AST_IRQ_RAISE: assert property ((irq_enable && $rose(s_r.write_collision_flag_f)) |-> irq)
        else $error("interrupt missing on collision");
    AST_WRITE_COLLISION_FLAG_SET: assert property ((dat_wr && !s_r.txe) |=> s_r.write_collision_flag_f)
        else $error("write collision not flagged");
    AST_WRITE_COLLISION_FLAG_DROP: assert property ((dat_wr && !s_r.txe) |=> $stable(s_r.tx_buf))
        else $error("colliding write changed buffer");
    AST_MODE_FAULT_FLAG_SET: assert property ((s_r.en && s_r.mst && s_r.mode == 2'h1 && !s_r.nss_s2)
        |=> s_r.mode_fault_flag_f)
        else $error("mode fault not flagged");
    AST_OVRN_SET: assert property ((s_done && rx_out_valid) |=> s_r.ovrn_f)
        else $error("overrun not flagged");
    AST_OVRN_SLAVE: assert property ($rose(s_r.ovrn_f) && !$past(ctl_wr) |-> !$past(s_r.mst))
        else $error("overrun flagged in master mode");
    AST_THREE_WIRE: assert property ((s_r.mode == 2'h0) |-> !nss_oe)
        else $error("select pin driven in three-wire mode");
    AST_FOUR_WIRE: assert property ((s_r.mode == 2'h1 && s_r.en && !s_r.mst && s_r.nss_s2)
        |-> !miso_oe && !nss_oe)
        else $error("deselected slave drives a pin");
    AST_TXE_CLEAR: assert property ((dat_wr && s_r.txe) |=> !s_r.txe)
        else $error("transmit empty not cleared");
    // An idle master with room to receive must take the new byte on the second edge after the write strobe.
    AST_TXE_RELOAD: assert property ((dat_wr && s_r.txe && s_r.en && s_r.mst
        && s_r.st == SCL_IDLE && !s_r.push && rx_in_ready) |=> !s_r.txe ##1 s_r.txe)
        else $error("transmit buffer not moved to the shift register");
    AST_TXE_SET: assert property (m_start |=> s_r.txe && s_r.st == SCL_XFER
        ##1 sck_out == 1'b0)
        else $error("transmit empty not set on load");
    // A write that enables the port is excluded, since the pins may wake on the next edge.
    AST_DISABLED: assert property ((!s_r.en && !ctl_wr)
        |=> !sck_out && !miso_oe && !mosi_oe)
        else $error("disabled port is active");
    AST_SCK_START: assert property (m_start |=> s_r.st == SCL_XFER [*4] ##1 sck_out)
        else $error("master clock did not start");

    COV_MASTER_DONE: cover property (m_done ##1 s_r.done_f);
    COV_SLAVE_DONE: cover property (s_done ##1 s_r.done_f);
    COV_COLLISION: cover property (dat_wr && !s_r.txe);
    COV_OVERRUN: cover property (s_done && rx_out_valid);
    COV_MODE_FAULT: cover property ($rose(s_r.mode_fault_flag_f));

endmodule

`default_nettype wire

/* File: test/scl_peer.sv */
`timescale 1ns/1ps
`default_nettype none

// Far-side serial device: a slave while the block is master, a master while it is slave.
module scl_peer (
    // Pins driven by the block.
    input  wire logic sck_out,
    input  wire logic sck_oe,
    input  wire logic mosi_out,
    input  wire logic miso_out,
    // Pins driven by this model.
    output logic      sck_in,
    output logic      mosi_in,
    output logic      miso_in,
    output logic      nss_in
);
    logic [7:0] stx;
    logic [7:0] srx;

    // Idle levels; the link clock stands still outside frames.
    initial begin
        sck_in  = 1'b0;
        mosi_in = 1'b0;
        nss_in  = 1'b1;
        stx     = 8'h00;
        srx     = 8'h00;
    end

    // A released data line shows the inverse of its last bit, so a stale value never passes.
    assign miso_in = sck_oe ? stx[7] : ~stx[7];

    // Slave side: sample on the rising clock, shift out on the falling one, MSB first.
    always @(posedge sck_out) srx = {srx[6:0], mosi_out};
    always @(negedge sck_out) stx = {stx[6:0], 1'b0};

    // Preloads the byte the slave side returns.
    task automatic load(input logic [7:0] b);
        stx = b;
    endtask

    // Drives the select line on its own.
    task automatic select(input logic v);
        nss_in = v;
    endtask

    // One master frame; the odd start delay keeps the link out of phase with the core clock.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #7 nss_in = 1'b0;
        #100;
        for (int i = 7; i >= 0; i--) begin
            mosi_in = tx[i];
            #80 sck_in = 1'b1;
            rx = {rx[6:0], miso_out};
            #80 sck_in = 1'b0;
        end
        #100 nss_in = 1'b1;
        mosi_in = ~mosi_in;
    endtask
endmodule

`default_nettype wire

/* File: test/spi_control_status_logic_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scl_cfg.svh"

module spi_control_status_logic_test;
    import scl_pkg::*;

    logic       core_clk;
    logic       rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       irq_enable;
    logic       irq;
    logic       sck_in;
    logic       sck_out;
    logic       sck_oe;
    logic       mosi_in;
    logic       mosi_out;
    logic       mosi_oe;
    logic       miso_in;
    logic       miso_out;
    logic       miso_oe;
    logic       nss_in;
    logic       nss_out;
    logic       nss_oe;
    logic [7:0] v;
    int         n_fail;
    int         compares;

    scl_ctl #(.HALF_CYC(8'h04)) dut_u (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_enable(irq_enable),
        .irq(irq), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_in),
        .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out),
        .miso_oe(miso_oe), .nss_in(nss_in), .nss_out(nss_out), .nss_oe(nss_oe)
    );

    scl_peer peer_u (
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out), .miso_out(miso_out),
        .sck_in(sck_in), .mosi_in(mosi_in), .miso_in(miso_in), .nss_in(nss_in)
    );

    // 50 MHz core clock.
    always #10 core_clk = ~core_clk;

    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // Two data writes with no gap, so the second meets a full transmit buffer.
    task automatic wr2(input logic [7:0] d0, input logic [7:0] d1);
        @(posedge core_clk);
        reg_addr  <= `SCL_DAT_ADDR;
        reg_wdata <= d0;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wdata <= d1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data are taken in the single cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Polls the control register under a bounded count until a flag shows.
    task automatic wait_flag(input logic [7:0] mask);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 300 && (c & mask) !== mask; i++) begin
            rd(`SCL_CTL_ADDR, c);
        end
        chk(c & mask, mask);
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog: the tests need a few hundred cycles; this allows twenty thousand.
    initial begin
        #400000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report;
    end

    // Main sequence.
    initial begin
        core_clk   = 1'b0;
        rst        = 1'b1;
        reg_addr   = 8'h00;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        irq_enable = 1'b1;
        n_fail     = 0;
        compares   = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(`SCL_CTL_ADDR, v);
        chk(v, 8'h06);
        rd(8'h10, v);
        chk(v, 8'h00);
        $display("test reset done");
        // Pin modes with master on; the select output follows the mode's low bit.
        wr(`SCL_CFG_ADDR, 8'h40);
        for (int m = 0; m < 4; m++) begin
            wr(`SCL_CTL_ADDR, {4'h0, m[1:0], 2'b01});
            repeat (2) @(posedge core_clk);
            #1 chk({5'h0, sck_oe, nss_oe, nss_out}, {5'h0, 1'b1, m[1], m[0]});
        end
        wr(`SCL_CTL_ADDR, 8'h00);
        repeat (2) @(posedge core_clk);
        #1 chk({6'h0, sck_oe, mosi_oe}, 8'h00);
        $display("test pin modes done");
        // Master transfer with a colliding second write.
        wr(`SCL_CTL_ADDR, 8'h01);
        peer_u.load(8'h3c);
        wr2(8'ha5, 8'h5a);
        wait_flag(8'h80);
        rd(`SCL_CTL_ADDR, v);
        chk(v, 8'hc3);
        chk({7'h0, irq}, 8'h01);
        rd(`SCL_DAT_ADDR, v);
        chk(v, 8'h3c);
        chk(peer_u.srx, 8'ha5);
        wr(`SCL_CTL_ADDR, 8'h01);
        rd(`SCL_CTL_ADDR, v);
        chk(v, 8'h03);
        chk({7'h0, irq}, 8'h00);
        $display("test master done");
        // Mode fault: select pulled low while master in four-wire mode.
        wr(`SCL_CTL_ADDR, 8'h05);
        peer_u.select(1'b0);
        repeat (6) @(posedge core_clk);
        peer_u.select(1'b1);
        repeat (20) @(posedge core_clk);
        rd(`SCL_CTL_ADDR, v);
        chk(v & 8'h20, 8'h20);
        // The enable input is moved on a clock edge like the register port inputs.
        @(posedge core_clk);
        irq_enable <= 1'b0;
        @(posedge core_clk);
        #1 chk({7'h0, irq}, 8'h00);
        @(posedge core_clk);
        irq_enable <= 1'b1;
        wr(`SCL_CTL_ADDR, 8'h05);
        rd(`SCL_CTL_ADDR, v);
        chk(v & 8'h20, 8'h00);
        $display("test mode fault done");
        // Slave: two frames with no data read between them overrun the receive side.
        wr(`SCL_CFG_ADDR, 8'h00);
        wr(`SCL_DAT_ADDR, 8'hc3);
        // Selection alone loads the byte and shows its first bit; it stays loaded for the frame.
        peer_u.select(1'b0);
        repeat (6) @(posedge core_clk);
        #1 chk({6'h0, miso_oe, miso_out}, 8'h03);
        peer_u.select(1'b1);
        repeat (4) @(posedge core_clk);
        peer_u.xfer(8'h96, v);
        chk(v, 8'hc3);
        rd(`SCL_CTL_ADDR, v);
        chk(v & 8'h90, 8'h80);
        #1 chk({7'h0, miso_oe}, 8'h00);
        peer_u.xfer(8'h69, v);
        repeat (4) @(posedge core_clk);
        rd(`SCL_CTL_ADDR, v);
        chk(v & 8'h10, 8'h10);
        rd(`SCL_DAT_ADDR, v);
        chk(v, 8'h96);
        rd(`SCL_DAT_ADDR, v);
        chk(v, 8'h69);
        $display("test slave done");
        final_report;
    end
endmodule

`default_nettype wire
